// ==== test/ulpi_phy_startup_reset_bench.sv ====
// Self-checking bench: both ends of the start-up link face each other across one interface.
`timescale 1ns/1ps
`default_nettype none
`include "ulpi_startup_consts.svh"

module ulpi_phy_startup_reset_bench;
    import ulpi_startup_pkg::*;

    localparam int LOCK_EDGES = 4;
    localparam int REF_CYC    = 20;

    logic       clk_sys, nrst, ref_clock_in, refRun;
    logic       coreSupply, usb3v3Supply, ioSupply, uartMode;
    logic       coreStable, linkReady, holdStop;
    logic       cablePowered, vbusLost, vbusReturned;
    logic       syncMode, regAccessOnly, usbSignalEnable, pllLocked;
    logic       busReady, lowPowerReq;
    reg_level_t uartLevel;
    reg_level_t regulatorLevel;
    int         bad_count;
    int         checks;
    int         waited;

    ulpi_link_if bus ();

    // A short lock count keeps each start-up to a few hundred cycles.
    ulpi_phy_startup #(.POR_CYC(2), .LOCK_EDGES(LOCK_EDGES), .REF_TIMEOUT(32), .ICLK_HALF(2)) i_ulpi_phy_startup (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus.phy), .coreSupply(coreSupply), .usb3v3Supply(usb3v3Supply),
        .ioSupply(ioSupply), .refClockIn(ref_clock_in), .uartMode(uartMode), .uartRegulatorLevelSel(uartLevel),
        .syncMode(syncMode), .regAccessOnly(regAccessOnly), .usbSignalEnable(usbSignalEnable),
        .regulatorLevel(regulatorLevel), .pllLocked(pllLocked));

    ulpi_link_startup i_ulpi_link_startup (
        .clk_sys(clk_sys), .nrst(nrst), .bus(bus.link), .coreStable(coreStable), .linkReady(linkReady),
        .holdStop(holdStop), .cablePowered(cablePowered), .vbusLost(vbusLost), .vbusReturned(vbusReturned),
        .busReady(busReady), .lowPowerReq(lowPowerReq));

    ulpi_phy_startup_reset_sva i_ulpi_phy_startup_reset_sva (
        .clk_sys(clk_sys), .nrst(nrst), .phyResetLow(bus.phyResetLow), .stp(bus.stp), .dir(bus.dir),
        .phyActive(bus.phyActive), .interfaceClock(bus.interfaceClock), .phyDataOe(bus.phyDataOe),
        .linkDataOe(bus.linkDataOe), .dataBus(bus.dataBus));

    // System clock, 8 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Reference clock, 160 ns period with an odd phase; it parks low while stopped.
    initial begin
        ref_clock_in = 1'b0;
        #13;
        forever #80 ref_clock_in = refRun ? ~ref_clock_in : 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic summarize();
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Waits for dir, busReady or lowPowerReq to reach a level; the cycles taken land in waited.
    task automatic wait_for(input int which, input logic level);
        logic seen;
        waited = 0;
        seen = ~level;
        while (seen !== level && waited < 3000) begin
            tick(1);
            waited++;
            case (which)
                0: seen = bus.dir;
                1: seen = busReady;
                default: seen = lowPowerReq;
            endcase
        end
        if (seen !== level) begin
            bad_count++;
            summarize();
        end
    endtask : wait_for

    task automatic test_startup();
        tick(40);
        check(bus.phyActive, 8'h00);
        check(bus.dir, 8'h00);
        coreStable = 1'b1;
        linkReady = 1'b1;
        wait_for(0, 1'b1);
        check(bus.dataBus, `ULPI_IDLE);
        check(pllLocked, 8'h00);
        wait_for(0, 1'b0);
        tick(2);
        check(pllLocked, 8'h01);
        check(syncMode, 8'h01);
        check(regAccessOnly, 8'h01);
        check(usbSignalEnable, 8'h00);
        wait_for(1, 1'b1);
    endtask : test_startup

    // A low pulse well short of the least reset time must leave the running transceiver alone.
    task automatic test_glitch();
        coreStable = 1'b0;
        tick(60);
        coreStable = 1'b1;
        tick(10);
        check(bus.phyActive, 8'h01);
        check(bus.dir, 8'h00);
    endtask : test_glitch

    task automatic test_level_and_stop();
        uartMode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            uartLevel = i[1:0];
            tick(2);
            check(regulatorLevel, i[7:0]);
        end
        uartMode = 1'b0;
        uartLevel = 2'h1;
        tick(2);
        check(regulatorLevel, 8'h03);
        coreStable = 1'b0;
        holdStop = 1'b1;
        tick(140);
        check(bus.phyActive, 8'h00);
        check(regulatorLevel, 8'h00);
        usb3v3Supply = 1'b1;
        coreStable = 1'b1;
        wait_for(0, 1'b1);
        tick(300);
        check(pllLocked, 8'h01);
        check(bus.dir, 8'h01);
        holdStop = 1'b0;
        wait_for(0, 1'b0);
        tick(2);
        check(usbSignalEnable, 8'h01);
        check(regulatorLevel, 8'h00);
        wait_for(1, 1'b1);
    endtask : test_level_and_stop

    // The reference clock starts long after the release, so start-up counts from its start.
    task automatic test_ref_late();
        coreStable = 1'b0;
        tick(140);
        refRun = 1'b0;
        tick(30);
        coreStable = 1'b1;
        tick(200);
        check(bus.dir, 8'h01);
        check(pllLocked, 8'h00);
        refRun = 1'b1;
        wait_for(0, 1'b0);
        check(waited >= (LOCK_EDGES - 1) * REF_CYC && waited <= (LOCK_EDGES + 3) * REF_CYC, 8'h01);
        wait_for(1, 1'b1);
    endtask : test_ref_late

    task automatic test_core_cycle();
        uartMode = 1'b1;
        tick(3);
        check(regulatorLevel, 8'h01);
        coreStable = 1'b0;
        tick(2);
        coreSupply = 1'b0;
        tick(10);
        check(bus.phyActive, 8'h00);
        check(bus.dir, 8'h00);
        check(regulatorLevel, 8'h00);
        uartMode = 1'b0;
        coreSupply = 1'b1;
        tick(20);
        coreStable = 1'b1;
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        check(regulatorLevel, 8'h00);
        wait_for(1, 1'b1);
    endtask : test_core_cycle

    task automatic test_low_power();
        cablePowered = 1'b1;
        vbusLost = 1'b1;
        wait_for(2, 1'b1);
        check(waited <= 2, 8'h01);
        vbusLost = 1'b0;
        vbusReturned = 1'b1;
        wait_for(2, 1'b0);
        vbusReturned = 1'b0;
        cablePowered = 1'b0;
    endtask : test_low_power

    // Main sequence: every input gets a value at time zero, then reset is held for 3 cycles.
    initial begin
        bad_count = 0;
        checks = 0;
        nrst = 1'b0;
        refRun = 1'b1;
        coreSupply = 1'b1;
        usb3v3Supply = 1'b0;
        ioSupply = 1'b1;
        uartMode = 1'b0;
        uartLevel = 2'h0;
        coreStable = 1'b0;
        linkReady = 1'b0;
        holdStop = 1'b0;
        cablePowered = 1'b0;
        vbusLost = 1'b0;
        vbusReturned = 1'b0;
        tick(3);
        nrst = 1'b1;
        test_startup();
        test_glitch();
        test_level_and_stop();
        test_ref_late();
        test_core_cycle();
        test_low_power();
        summarize();
    end

endmodule : ulpi_phy_startup_reset_bench

`default_nettype wire

// ==== test/ulpi_phy_startup_reset_sva.sv ====
// Concurrent checks on the pins between the transceiver and its link controller.
`timescale 1ns/1ps
`default_nettype none
`include "ulpi_startup_consts.svh"

module ulpi_phy_startup_reset_sva
    import ulpi_startup_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       phyResetLow,
    input wire logic       stp,
    input wire logic       dir,
    input wire logic       phyActive,
    input wire logic       interfaceClock,
    input wire logic       phyDataOe,
    input wire logic       linkDataOe,
    input wire ulpi_data_t dataBus
);
    logic [7:0] lowCnt_r;
    logic [7:0] lowCnt_nxt;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Counts low cycles of the reset pin; it saturates so that a long hold stays visible.
    always_comb begin
        lowCnt_nxt = phyResetLow ? 8'h00 : lowCnt_r + {7'h00, lowCnt_r != 8'hFF};
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lowCnt_r <= 8'h00;
        end else begin
            lowCnt_r <= lowCnt_nxt;
        end
    end

    // The figures below assume the interface clock half period of two system cycles.
    a_idle_while_dir: assert property (dir |-> phyDataOe && dataBus == `ULPI_IDLE)
        else $error("bus not idle while dir is high");
    a_dir_with_start: assert property ($rose(phyActive) |-> dir)
        else $error("pins enabled without dir high");
    a_release_synced: assert property ($rose(phyActive) |-> $past(phyResetLow, 2) && $past(phyResetLow, 3))
        else $error("start-up acted on an unsynchronized reset release");
    a_stp_keeps_dir: assert property ((dir && stp && phyResetLow)[*4] |=> dir)
        else $error("dir dropped while stp high");
    a_stp_low_first: assert property ($fell(dir) && phyActive |-> !$past(stp, 3))
        else $error("dir released without stp low");
    a_link_takes_bus: assert property ($fell(dir) && phyActive |-> ##[2:24] linkDataOe)
        else $error("link did not take the bus after hand-over");
    a_link_waits: assert property ($rose(linkDataOe) |-> !dir && !$past(dir) && !$past(dir, 2))
        else $error("link drove the bus too early");
    a_long_low_resets: assert property (lowCnt_r >= 8'h84 |-> !dir && !phyActive)
        else $error("long reset low did not reset the device");
    a_clock_unlocked: assert property ($rose(dir) |-> !interfaceClock)
        else $error("interface clock running before lock");
    a_clock_half: assert property ($rose(interfaceClock) && phyResetLow |=> interfaceClock ##1 !interfaceClock)
        else $error("interface clock half period wrong");

endmodule : ulpi_phy_startup_reset_sva

`default_nettype wire

// ==== verilog/ulpi_link_if.sv ====
// Pins between the transceiver and its link controller, with the shared data bus resolved.
`timescale 1ns/1ps
`default_nettype none
`include "ulpi_startup_consts.svh"

interface ulpi_link_if;
    import ulpi_startup_pkg::*;

    logic       phyResetLow;
    logic       stp;
    logic       dir;
    logic       phyActive;
    logic       interfaceClock;
    ulpi_data_t phyData;
    logic       phyDataOe;
    ulpi_data_t linkData;
    logic       linkDataOe;
    ulpi_data_t dataBus;

    // The bus carries whichever end enables its drivers; nobody driving reads as idle.
    assign dataBus = phyDataOe ? phyData : (linkDataOe ? linkData : `ULPI_IDLE);

    modport phy (
        input  phyResetLow,
        input  stp,
        input  linkData,
        input  linkDataOe,
        input  dataBus,
        output dir,
        output phyActive,
        output interfaceClock,
        output phyData,
        output phyDataOe
    );

    modport link (
        output phyResetLow,
        output stp,
        output linkData,
        output linkDataOe,
        input  dataBus,
        input  dir,
        input  phyActive,
        input  interfaceClock,
        input  phyData,
        input  phyDataOe
    );

endinterface : ulpi_link_if

`default_nettype wire

// ==== verilog/ulpi_link_startup.sv ====
// Link controller end: drives the reset pin and STP, and takes the bus after the hand-over.
`timescale 1ns/1ps
`default_nettype none
`include "ulpi_startup_consts.svh"

module ulpi_link_startup
    import ulpi_startup_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    ulpi_link_if.link bus,
    input  wire logic coreStable,
    input  wire logic linkReady,
    input  wire logic holdStop,
    input  wire logic cablePowered,
    input  wire logic vbusLost,
    input  wire logic vbusReturned,
    output logic      busReady,
    output logic      lowPowerReq
);

    // Interface clock and DIR come from the other chip and pass two flops.
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic       iclkPrev_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_r    <= 2'h0;
            sync2_r    <= 2'h0;
            iclkPrev_r <= 1'b0;
        end else begin
            sync1_r    <= {bus.dir, bus.interfaceClock};
            sync2_r    <= sync1_r;
            iclkPrev_r <= sync2_r[0];
        end
    end

    logic iclkRise;
    logic dirS;
    assign iclkRise = sync2_r[0] && !iclkPrev_r;
    assign dirS     = sync2_r[1];

    // Reset pin, STP and the low-power request.
    logic       rstHigh_r;
    logic       rstHigh_nxt;
    logic       stp_r;
    logic       stp_nxt;
    logic       lowPow_r;
    logic       lowPow_nxt;

    always_comb begin
        // The pin is driven from reset onward and rises only once the core supply is stable.
        rstHigh_nxt = coreStable && linkReady;
        stp_nxt     = holdStop;
        // A new loss of VBUS on a powered cable wins over a return reported in the same cycle.
        if (cablePowered && vbusLost) begin
            lowPow_nxt = 1'b1;
        end else if (vbusReturned) begin
            lowPow_nxt = 1'b0;
        end else begin
            lowPow_nxt = lowPow_r;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstHigh_r <= 1'b0;
            stp_r     <= 1'b0;
            lowPow_r  <= 1'b0;
        end else begin
            rstHigh_r <= rstHigh_nxt;
            stp_r     <= stp_nxt;
            lowPow_r  <= lowPow_nxt;
        end
    end

    // Hand-over tracker: waits for DIR high then low, then drives idle one interface cycle later.
    link_state_t state_r;
    link_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (!rstHigh_r) begin
            state_nxt = L_RESET;
        end else begin
            case (state_r)
                L_RESET: begin
                    state_nxt = L_WAIT_HIGH;
                end
                L_WAIT_HIGH: begin
                    if (dirS) begin
                        state_nxt = L_WAIT_LOW;
                    end
                end
                L_WAIT_LOW: begin
                    if (iclkRise && !dirS) begin
                        state_nxt = L_DELAY;
                    end
                end
                L_DELAY: begin
                    if (dirS) begin
                        state_nxt = L_WAIT_LOW;
                    end else if (iclkRise) begin
                        state_nxt = L_RUN;
                    end
                end
                L_RUN: begin
                    if (dirS) begin
                        state_nxt = L_WAIT_LOW;
                    end
                end
                default: begin
                    state_nxt = L_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= L_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign bus.phyResetLow = rstHigh_r;
    assign bus.stp         = stp_r;
    assign bus.linkData    = `ULPI_IDLE;
    assign bus.linkDataOe  = (state_r == L_RUN);
    assign busReady        = (state_r == L_RUN);
    assign lowPowerReq     = lowPow_r;

endmodule : ulpi_link_startup

`default_nettype wire

// ==== verilog/ulpi_phy_startup.sv ====
// Transceiver end: power-on reset, reset pin filter, PLL lock model and bus hand-over.
`timescale 1ns/1ps
`default_nettype none
`include "ulpi_startup_consts.svh"

module ulpi_phy_startup
    import ulpi_startup_pkg::*;
#(
    parameter int POR_CYC     = `POR_CYC,
    parameter int LOCK_EDGES  = `PLL_LOCK_EDGES,
    parameter int REF_TIMEOUT = `REF_TIMEOUT_CYC,
    parameter int ICLK_HALF   = `ICLK_HALF_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    ulpi_link_if.phy        bus,
    input  wire logic       coreSupply,
    input  wire logic       usb3v3Supply,
    input  wire logic       ioSupply,
    input  wire logic       refClockIn,
    input  wire logic       uartMode,
    input  wire reg_level_t uartRegulatorLevelSel,
    output logic            syncMode,
    output logic            regAccessOnly,
    output logic            usbSignalEnable,
    output reg_level_t      regulatorLevel,
    output logic            pllLocked
);

    localparam logic [`RST_CNT_W-1:0] RST_MIN = `RST_CNT_W'(`RST_MIN_CYC);

    // Pin inputs enter through two flops; only the second stage is read by logic.
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] pinsRaw;
    assign pinsRaw = {bus.stp, bus.phyResetLow, refClockIn, ioSupply, usb3v3Supply, coreSupply};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= pinsRaw;
            sync2_r <= sync1_r;
        end
    end

    logic coreS;
    logic v33S;
    logic ioS;
    logic refS;
    logic rstHighS;
    logic stpS;
    assign coreS    = sync2_r[0];
    assign v33S     = sync2_r[1];
    assign ioS      = sync2_r[2];
    assign refS     = sync2_r[3];
    assign rstHighS = sync2_r[4];
    assign stpS     = sync2_r[5];

    // Reset pin low-time filter and reference edge detector.
    logic [`RST_CNT_W-1:0] lowCnt_r;
    logic [`RST_CNT_W-1:0] lowCnt_nxt;
    logic                  refPrev_r;
    logic                  refPrev_nxt;
    logic                  rstAccepted;
    logic                  refRise;

    always_comb begin
        refPrev_nxt = refS;
        if (rstHighS) begin
            lowCnt_nxt = '0;
        end else if (lowCnt_r != RST_MIN) begin
            lowCnt_nxt = lowCnt_r + `RST_CNT_W'(1);
        end else begin
            lowCnt_nxt = lowCnt_r;
        end
    end

    // Pulses shorter than the least low time are ignored, so a glitch cannot wipe the registers.
    assign rstAccepted = (lowCnt_r == RST_MIN);
    assign refRise     = refS && !refPrev_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lowCnt_r  <= '0;
            refPrev_r <= 1'b0;
        end else begin
            lowCnt_r  <= lowCnt_nxt;
            refPrev_r <= refPrev_nxt;
        end
    end

    // Start-up sequencer with its counters.
    phy_state_t  state_r;
    phy_state_t  state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] idle_r;
    logic [15:0] idle_nxt;
    logic        lock_r;
    logic        lock_nxt;
    logic        iclkTick;
    logic        refLost;

    // Lock is lost when the reference clock stops, as a real PLL would drift out.
    assign refLost = (idle_r >= 16'(REF_TIMEOUT));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        lock_nxt  = lock_r;
        idle_nxt  = refRise ? 16'h0000 : ((idle_r == 16'hFFFF) ? idle_r : idle_r + 16'h0001);
        if (!coreS) begin
            state_nxt = PWR_OFF;
            lock_nxt  = 1'b0;
        end else if (rstAccepted && state_r != PWR_OFF && state_r != POR_WAIT) begin
            state_nxt = RST_HOLD;
            lock_nxt  = 1'b0;
        end else begin
            case (state_r)
                PWR_OFF: begin
                    state_nxt = POR_WAIT;
                    cnt_nxt   = 16'h0000;
                end
                POR_WAIT: begin
                    cnt_nxt = cnt_r + 16'h0001;
                    if (cnt_r >= 16'(POR_CYC)) begin
                        state_nxt = RST_HOLD;
                    end
                end
                RST_HOLD: begin
                    if (rstHighS && ioS) begin
                        state_nxt = REF_WAIT;
                    end
                end
                REF_WAIT: begin
                    if (refRise) begin
                        state_nxt = PLL_LOCKING;
                        cnt_nxt   = 16'h0001;
                    end
                end
                PLL_LOCKING: begin
                    if (refLost) begin
                        state_nxt = REF_WAIT;
                    end else if (refRise) begin
                        cnt_nxt = cnt_r + 16'h0001;
                        if (cnt_r + 16'h0001 >= 16'(LOCK_EDGES)) begin
                            state_nxt = STP_WAIT;
                            lock_nxt  = 1'b1;
                        end
                    end
                end
                STP_WAIT: begin
                    if (refLost) begin
                        state_nxt = REF_WAIT;
                        lock_nxt  = 1'b0;
                    end else if (iclkTick && lock_r && !stpS) begin
                        state_nxt = BUS_RUN;
                    end
                end
                BUS_RUN: begin
                    if (refLost) begin
                        state_nxt = REF_WAIT;
                        lock_nxt  = 1'b0;
                    end
                end
                default: begin
                    state_nxt = PWR_OFF;
                    lock_nxt  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= PWR_OFF;
            cnt_r   <= 16'h0000;
            idle_r  <= 16'h0000;
            lock_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            idle_r  <= idle_nxt;
            lock_r  <= lock_nxt;
        end
    end

    // Interface clock divider; it runs only while the PLL model is locked.
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic       iclk_r;
    logic       iclk_nxt;

    always_comb begin
        div_nxt  = div_r;
        iclk_nxt = iclk_r;
        if (!lock_r) begin
            div_nxt  = 8'h00;
            iclk_nxt = 1'b0;
        end else if (div_r >= 8'(ICLK_HALF - 1)) begin
            div_nxt  = 8'h00;
            iclk_nxt = !iclk_r;
        end else begin
            div_nxt = div_r + 8'h01;
        end
    end

    // The hand-over from STP_WAIT to BUS_RUN, and so the fall of dir, lands on the interface clock's rising edge.
    assign iclkTick = lock_r && !iclk_r && (div_r >= 8'(ICLK_HALF - 1));

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_r  <= 8'h00;
            iclk_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            iclk_r <= iclk_nxt;
        end
    end

    // Pin drivers, operating mode flags and the regulator level field.
    logic       dir_r;
    logic       dir_nxt;
    logic       active_r;
    logic       active_nxt;
    logic       sync_r;
    logic       sync_nxt;
    logic       regOnly_r;
    logic       regOnly_nxt;
    logic       usbEn_r;
    logic       usbEn_nxt;
    reg_level_t level_r;
    reg_level_t level_nxt;
    logic       starting;
    logic       defaults;

    assign starting = (state_nxt == REF_WAIT) || (state_nxt == PLL_LOCKING) || (state_nxt == STP_WAIT);
    assign defaults = (state_nxt == PWR_OFF) || (state_nxt == POR_WAIT) || (state_nxt == RST_HOLD);

    always_comb begin
        active_nxt  = !defaults;
        dir_nxt     = starting;
        sync_nxt    = (state_nxt == BUS_RUN);
        regOnly_nxt = (state_nxt == BUS_RUN) && !v33S;
        usbEn_nxt   = (state_nxt == BUS_RUN) && v33S;
        if (defaults) begin
            level_nxt = `REG_LEVEL_DEF;
        end else if (state_nxt == BUS_RUN && uartMode) begin
            level_nxt = uartRegulatorLevelSel;
        end else begin
            level_nxt = level_r;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dir_r     <= 1'b0;
            active_r  <= 1'b0;
            sync_r    <= 1'b0;
            regOnly_r <= 1'b0;
            usbEn_r   <= 1'b0;
            level_r   <= `REG_LEVEL_DEF;
        end else begin
            dir_r     <= dir_nxt;
            active_r  <= active_nxt;
            sync_r    <= sync_nxt;
            regOnly_r <= regOnly_nxt;
            usbEn_r   <= usbEn_nxt;
            level_r   <= level_nxt;
        end
    end

    assign bus.dir            = dir_r;
    assign bus.phyActive      = active_r;
    assign bus.interfaceClock = iclk_r;
    assign bus.phyData        = `ULPI_IDLE;
    assign bus.phyDataOe      = dir_r;
    assign syncMode           = sync_r;
    assign regAccessOnly      = regOnly_r;
    assign usbSignalEnable    = usbEn_r;
    assign regulatorLevel     = level_r;
    assign pllLocked          = lock_r;

endmodule : ulpi_phy_startup

`default_nettype wire

// ==== verilog/ulpi_startup_consts.svh ====
// Timing counts, reset values and bus constants for the transceiver start-up logic.
`ifndef ULPI_STARTUP_CONSTS_SVH
`define ULPI_STARTUP_CONSTS_SVH

// System clock period in nanoseconds (125 MHz).
`define CLK_PERIOD_NS 8
// Least low time on the external reset pin that resets the device, in nanoseconds.
`define RST_MIN_NS 1000
// Least time rounds up to whole cycles.
`define RST_MIN_CYC ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Width of the reset low-time counter.
`define RST_CNT_W 8
// Cycles the internal power-on reset stays active after the core supply appears.
`define POR_CYC 16
// Reference clock rising edges the PLL model needs before it reports lock.
`define PLL_LOCK_EDGES 32
// System cycles without a reference edge after which lock is considered lost.
`define REF_TIMEOUT_CYC 64
// Half period of the interface clock in system cycles.
`define ICLK_HALF_CYC 2
// Value driven on the data bus while idle.
`define ULPI_IDLE 8'h00
// Default regulator output level code.
`define REG_LEVEL_DEF 2'h0

`endif

// ==== verilog/ulpi_startup_pkg.sv ====
// Types shared by both ends of the transceiver start-up link.
package ulpi_startup_pkg;

    // Start-up sequence of the transceiver.
    typedef enum logic [2:0] {
        PWR_OFF,
        POR_WAIT,
        RST_HOLD,
        REF_WAIT,
        PLL_LOCKING,
        STP_WAIT,
        BUS_RUN
    } phy_state_t;

    // Start-up sequence seen from the link controller.
    typedef enum logic [2:0] {
        L_RESET,
        L_WAIT_HIGH,
        L_WAIT_LOW,
        L_DELAY,
        L_RUN
    } link_state_t;

    typedef logic [7:0] ulpi_data_t;
    typedef logic [1:0] reg_level_t;

endpackage : ulpi_startup_pkg
